// ---- rtl/mbc_link_if.sv ----
interface mbc_link_if;
    // master to slave byte stream
    logic [7:0] m2s_data;
    logic m2s_valid;
    logic m2s_last;
    // slave to master byte stream
    logic [7:0] s2m_data;
    logic s2m_valid;
    logic s2m_last;

    modport dev (
        input m2s_data,
        input m2s_valid,
        input m2s_last,
        output s2m_data,
        output s2m_valid,
        output s2m_last
    );

    modport ctl (
        output m2s_data,
        output m2s_valid,
        output m2s_last,
        input s2m_data,
        input s2m_valid,
        input s2m_last
    );
endinterface : mbc_link_if

// ---- rtl/mbc_master.sv ----
module mbc_master
    import mbc_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = RSP_TIMEOUT_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link
    mbc_link_if.ctl link,
    // request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_word1,
    input wire logic [15:0] req_word2,
    // response
    output logic rsp_done,
    output logic rsp_ok,
    output logic rsp_exc,
    output logic rsp_timeout,
    output logic rsp_echo_ok,
    output logic [7:0] rsp_code,
    input wire logic [3:0] rsp_rd_idx,
    output logic [15:0] rsp_word
);

    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_TX = 3'b010,
        M_RX = 3'b100
    } mbc_mst_state_t;

    mbc_mst_state_t st_q, st_d;
    logic [7:0] f_q [6];
    logic [7:0] f_d [6];
    logic [7:0] rxb_q [37];
    logic [7:0] rxb_d [37];
    logic [2:0] idx_q, idx_d;
    logic [5:0] cnt_q, cnt_d;
    logic [15:0] crc_q, crc_d;
    logic [15:0] crc_p1_q, crc_p1_d;
    logic [7:0] prev_q, prev_d;
    logic [31:0] tmr_q, tmr_d;
    logic [7:0] m_data_q, m_data_d;
    logic m_valid_q, m_valid_d;
    logic m_last_q, m_last_d;
    logic ready_q, ready_d;
    logic done_q, done_d;
    logic ok_q, ok_d;
    logic exc_q, exc_d;
    logic tmo_q, tmo_d;
    logic echo_q, echo_d;
    logic [7:0] code_q, code_d;
    logic [15:0] word_q, word_d;
    logic [5:0] wsel;

    logic frame_ok;
    assign wsel = {1'b0, rsp_rd_idx, 1'b0} + 6'h03;
    // received checksum is the two bytes after the covered ones
    assign frame_ok = (cnt_q >= 6'h03) && ({link.s2m_data, prev_q} == crc_p1_q)
                      && (rxb_q[0] == f_q[0]);

    always_comb begin
        st_d = st_q;
        f_d = f_q;
        rxb_d = rxb_q;
        idx_d = idx_q;
        cnt_d = cnt_q;
        crc_d = crc_q;
        crc_p1_d = crc_p1_q;
        prev_d = prev_q;
        tmr_d = tmr_q;
        m_data_d = m_data_q;
        m_valid_d = 1'b0;
        m_last_d = 1'b0;
        ready_d = ready_q;
        done_d = 1'b0;
        ok_d = ok_q;
        exc_d = exc_q;
        tmo_d = tmo_q;
        echo_d = echo_q;
        code_d = code_q;
        word_d = {rxb_q[wsel], rxb_q[wsel + 6'h01]};
        case (st_q)
            M_IDLE: begin
                if (req_valid && ready_q) begin
                    f_d[0] = req_addr;
                    f_d[1] = req_func;
                    f_d[2] = req_word1[15:8];
                    f_d[3] = req_word1[7:0];
                    f_d[4] = req_word2[15:8];
                    f_d[5] = req_word2[7:0];
                    idx_d = 3'h0;
                    crc_d = CRC_PRESET;
                    ready_d = 1'b0;
                    st_d = M_TX;
                end
            end
            M_TX: begin
                m_valid_d = 1'b1;
                idx_d = idx_q + 3'h1;
                if (idx_q < 3'h6) begin
                    m_data_d = f_q[idx_q];
                    crc_d = crc_byte(crc_q, f_q[idx_q]);
                end else begin
                    m_data_d = (idx_q == 3'h6) ? crc_q[7:0] : crc_q[15:8];
                end
                if (idx_q == 3'h7) begin
                    m_last_d = 1'b1;
                    crc_d = CRC_PRESET;
                    crc_p1_d = CRC_PRESET;
                    cnt_d = 6'h00;
                    tmr_d = 32'h0;
                    ok_d = 1'b0;
                    exc_d = 1'b0;
                    tmo_d = 1'b0;
                    echo_d = 1'b0;
                    if (f_q[0] == BCAST_ADDR) begin
                        done_d = 1'b1;
                        ready_d = 1'b1;
                        st_d = M_IDLE;
                    end else begin
                        st_d = M_RX;
                    end
                end
            end
            M_RX: begin
                tmr_d = tmr_q + 32'h1;
                if (link.s2m_valid) begin
                    if (cnt_q < RSP_MAX_BYTES) begin
                        rxb_d[cnt_q] = link.s2m_data;
                        cnt_d = cnt_q + 6'h01;
                    end
                    prev_d = link.s2m_data;
                    crc_p1_d = crc_q;
                    crc_d = crc_byte(crc_q, link.s2m_data);
                    if (link.s2m_last) begin
                        ok_d = frame_ok && (rxb_q[1] == f_q[1]);
                        exc_d = frame_ok && (rxb_q[1] == (f_q[1] | FN_EXC_BIT));
                        echo_d = frame_ok && (rxb_q[1] == FN_LOOP) && (cnt_q == 6'h07)
                                 && (rxb_q[2] == f_q[2]) && (rxb_q[3] == f_q[3])
                                 && (rxb_q[4] == f_q[4]) && (rxb_q[5] == f_q[5]);
                        code_d = rxb_q[2];
                        done_d = 1'b1;
                        ready_d = 1'b1;
                        st_d = M_IDLE;
                    end
                end else if (tmr_q == TIMEOUT_CYC - 1) begin
                    tmo_d = 1'b1;
                    done_d = 1'b1;
                    ready_d = 1'b1;
                    st_d = M_IDLE;
                end
            end
            default: st_d = M_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= M_IDLE;
            for (int i = 0; i < 6; i++) begin
                f_q[i] <= 8'h00;
            end
            for (int i = 0; i < 37; i++) begin
                rxb_q[i] <= 8'h00;
            end
            idx_q <= 3'h0;
            cnt_q <= 6'h00;
            crc_q <= CRC_PRESET;
            crc_p1_q <= CRC_PRESET;
            prev_q <= 8'h00;
            tmr_q <= 32'h0;
            m_data_q <= 8'h00;
            m_valid_q <= 1'b0;
            m_last_q <= 1'b0;
            ready_q <= 1'b1;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            exc_q <= 1'b0;
            tmo_q <= 1'b0;
            echo_q <= 1'b0;
            code_q <= 8'h00;
            word_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            f_q <= f_d;
            rxb_q <= rxb_d;
            idx_q <= idx_d;
            cnt_q <= cnt_d;
            crc_q <= crc_d;
            crc_p1_q <= crc_p1_d;
            prev_q <= prev_d;
            tmr_q <= tmr_d;
            m_data_q <= m_data_d;
            m_valid_q <= m_valid_d;
            m_last_q <= m_last_d;
            ready_q <= ready_d;
            done_q <= done_d;
            ok_q <= ok_d;
            exc_q <= exc_d;
            tmo_q <= tmo_d;
            echo_q <= echo_d;
            code_q <= code_d;
            word_q <= word_d;
        end
    end

    assign link.m2s_data = m_data_q;
    assign link.m2s_valid = m_valid_q;
    assign link.m2s_last = m_last_q;
    assign req_ready = ready_q;
    assign rsp_done = done_q;
    assign rsp_ok = ok_q;
    assign rsp_exc = exc_q;
    assign rsp_timeout = tmo_q;
    assign rsp_echo_ok = echo_q;
    assign rsp_code = code_q;
    assign rsp_word = word_q;

endmodule : mbc_master

// ---- rtl/mbc_pkg.sv ----
package mbc_pkg;
    // checksum arithmetic
    localparam logic [15:0] CRC_PRESET = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;
    // function codes and station addresses
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_LOOP = 8'h08;
    localparam logic [7:0] FN_EXC_BIT = 8'h80;
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    // exception codes
    localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    // frame geometry
    localparam int unsigned MAX_READ_REGS = 16;
    localparam logic [3:0] CMD_LEN = 4'h8;
    localparam logic [5:0] RSP_OVERHEAD = 6'h05;
    localparam logic [5:0] EXC_LEN = 6'h05;
    localparam logic [5:0] ECHO_LEN = 6'h08;
    localparam logic [5:0] RSP_MAX_BYTES = 6'h25;
    // master gives up on a missing answer after this many cycles
    localparam int unsigned RSP_TIMEOUT_CYCLES = 4000;

    // one whole byte: fold in, then eight shift steps
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : crc_byte
endpackage : mbc_pkg

// ---- rtl/mbc_slave.sv ----
// Function
// - act only when received checksum matches computed
// - accumulator preset to FFFF per message
// - station address folded into low bits first
// - shift right, XOR A001 on carry out
// - eight shift steps per byte
// - next byte folded after eight shifts
// - final accumulator value is the checksum
// - master verifies response checksum the same way
// - read asks at most sixteen registers
// - loopback answer identical to the command
// - loopback echoes any test code and data
// - every register is exactly two bytes
// - address zero accepted, never answered
module mbc_slave
    import mbc_pkg::*;
#(
    parameter int unsigned MAX_REGS = MAX_READ_REGS
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // link
    mbc_link_if.dev link,
    // station identity
    input wire logic [7:0] own_addr,
    // register read port, data must follow reg_rd_addr in the same cycle
    output logic [15:0] reg_rd_addr,
    input wire logic [15:0] reg_rd_data,
    // accepted command
    output logic cmd_fire,
    output logic [7:0] cmd_func,
    output logic [15:0] cmd_word1,
    output logic [15:0] cmd_word2,
    output logic cmd_bcast,
    // rejected frame
    output logic frame_err
);

    typedef enum logic [1:0] {
        S_RX = 2'b01,
        S_TX = 2'b10
    } mbc_slv_state_t;

    typedef enum logic [1:0] {
        K_ECHO = 2'b00,
        K_READ = 2'b01,
        K_EXC = 2'b10
    } mbc_kind_t;

    mbc_slv_state_t st_q, st_d;
    mbc_kind_t kind_q, kind_d;
    logic [7:0] buf_q [8];
    logic [7:0] buf_d [8];
    logic [3:0] cnt_q, cnt_d;
    logic [15:0] rx_crc_q, rx_crc_d;
    logic [15:0] tx_crc_q, tx_crc_d;
    logic [5:0] idx_q, idx_d;
    logic [5:0] len_q, len_d;
    logic [4:0] qty_q, qty_d;
    logic [7:0] code_q, code_d;
    logic [15:0] rd_addr_q, rd_addr_d;
    logic [7:0] tx_data_q, tx_data_d;
    logic tx_valid_q, tx_valid_d;
    logic tx_last_q, tx_last_d;
    logic fire_q, fire_d;
    logic [7:0] func_q, func_d;
    logic [15:0] w1_q, w1_d;
    logic [15:0] w2_q, w2_d;
    logic bcast_q, bcast_d;
    logic err_q, err_d;

    logic [7:0] tx_byte;
    logic [15:0] rx_w1;
    logic [15:0] rx_w2;
    logic crc_ok;
    logic addr_ok;
    logic read_ok;

    assign rx_w1 = {buf_q[2], buf_q[3]};
    // last byte is still on the link, not yet in the buffer
    assign rx_w2 = {buf_q[4], buf_q[5]};
    assign crc_ok = ({link.m2s_data, buf_q[6]} == rx_crc_q);
    assign addr_ok = (buf_q[0] == own_addr) || (buf_q[0] == BCAST_ADDR);
    assign read_ok = (rx_w2 != 16'h0000) && (rx_w2 <= 16'(MAX_REGS));

    // byte to send at the current index
    always_comb begin
        tx_byte = 8'h00;
        if (idx_q == len_q - 6'h02) begin
            tx_byte = tx_crc_q[7:0];
        end else if (idx_q == len_q - 6'h01) begin
            tx_byte = tx_crc_q[15:8];
        end else begin
            case (kind_q)
                K_ECHO: begin
                    tx_byte = buf_q[idx_q[2:0]];
                end
                K_EXC: begin
                    case (idx_q)
                        6'h00: tx_byte = buf_q[0];
                        6'h01: tx_byte = buf_q[1] | FN_EXC_BIT;
                        default: tx_byte = code_q;
                    endcase
                end
                K_READ: begin
                    case (idx_q)
                        6'h00: tx_byte = buf_q[0];
                        6'h01: tx_byte = buf_q[1];
                        6'h02: tx_byte = {2'b00, qty_q, 1'b0};
                        default: begin
                            // odd index carries the high byte
                            tx_byte = idx_q[0] ? reg_rd_data[15:8] : reg_rd_data[7:0];
                        end
                    endcase
                end
                default: tx_byte = 8'h00;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        kind_d = kind_q;
        buf_d = buf_q;
        cnt_d = cnt_q;
        rx_crc_d = rx_crc_q;
        tx_crc_d = tx_crc_q;
        idx_d = idx_q;
        len_d = len_q;
        qty_d = qty_q;
        code_d = code_q;
        rd_addr_d = rd_addr_q;
        tx_data_d = tx_data_q;
        tx_valid_d = 1'b0;
        tx_last_d = 1'b0;
        fire_d = 1'b0;
        func_d = func_q;
        w1_d = w1_q;
        w2_d = w2_q;
        bcast_d = bcast_q;
        err_d = 1'b0;
        case (st_q)
            S_RX: begin
                if (link.m2s_valid) begin
                    if (cnt_q < CMD_LEN) begin
                        buf_d[cnt_q[2:0]] = link.m2s_data;
                    end
                    // checksum covers all but the two trailing bytes
                    if (cnt_q < CMD_LEN - 4'h2) begin
                        rx_crc_d = crc_byte(rx_crc_q, link.m2s_data);
                    end
                    if (cnt_q != 4'hF) begin
                        cnt_d = cnt_q + 4'h1;
                    end
                    if (link.m2s_last) begin
                        cnt_d = 4'h0;
                        rx_crc_d = CRC_PRESET;
                        if (cnt_q == CMD_LEN - 4'h1 && crc_ok) begin
                            if (addr_ok) begin
                                func_d = buf_q[1];
                                w1_d = rx_w1;
                                w2_d = rx_w2;
                                bcast_d = (buf_q[0] == BCAST_ADDR);
                                idx_d = 6'h00;
                                tx_crc_d = CRC_PRESET;
                                rd_addr_d = rx_w1;
                                qty_d = rx_w2[4:0];
                                if (buf_q[1] == FN_LOOP) begin
                                    fire_d = 1'b1;
                                    kind_d = K_ECHO;
                                    len_d = ECHO_LEN;
                                end else if (buf_q[1] == FN_READ && read_ok) begin
                                    fire_d = 1'b1;
                                    kind_d = K_READ;
                                    len_d = RSP_OVERHEAD + {rx_w2[4:0], 1'b0};
                                end else begin
                                    kind_d = K_EXC;
                                    len_d = EXC_LEN;
                                    code_d = (buf_q[1] == FN_READ) ? EXC_BAD_VALUE
                                                                   : EXC_ILLEGAL_FN;
                                end
                                // broadcast is acted on but never answered
                                if (buf_q[0] != BCAST_ADDR) begin
                                    st_d = S_TX;
                                end
                            end
                        end else begin
                            err_d = 1'b1;
                        end
                    end
                end
            end
            S_TX: begin
                // master must stay quiet while the answer goes out
                tx_valid_d = 1'b1;
                tx_data_d = tx_byte;
                if (idx_q < len_q - 6'h02) begin
                    tx_crc_d = crc_byte(tx_crc_q, tx_byte);
                end
                if (kind_q == K_READ && idx_q > 6'h02 && !idx_q[0]) begin
                    rd_addr_d = rd_addr_q + 16'h0001;
                end
                idx_d = idx_q + 6'h01;
                if (idx_q == len_q - 6'h01) begin
                    tx_last_d = 1'b1;
                    st_d = S_RX;
                end
            end
            default: st_d = S_RX;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q <= S_RX;
            kind_q <= K_ECHO;
            for (int i = 0; i < 8; i++) begin
                buf_q[i] <= 8'h00;
            end
            cnt_q <= 4'h0;
            rx_crc_q <= CRC_PRESET;
            tx_crc_q <= CRC_PRESET;
            idx_q <= 6'h00;
            len_q <= ECHO_LEN;
            qty_q <= 5'h00;
            code_q <= 8'h00;
            rd_addr_q <= 16'h0000;
            tx_data_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            fire_q <= 1'b0;
            func_q <= 8'h00;
            w1_q <= 16'h0000;
            w2_q <= 16'h0000;
            bcast_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            st_q <= st_d;
            kind_q <= kind_d;
            buf_q <= buf_d;
            cnt_q <= cnt_d;
            rx_crc_q <= rx_crc_d;
            tx_crc_q <= tx_crc_d;
            idx_q <= idx_d;
            len_q <= len_d;
            qty_q <= qty_d;
            code_q <= code_d;
            rd_addr_q <= rd_addr_d;
            tx_data_q <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            tx_last_q <= tx_last_d;
            fire_q <= fire_d;
            func_q <= func_d;
            w1_q <= w1_d;
            w2_q <= w2_d;
            bcast_q <= bcast_d;
            err_q <= err_d;
        end
    end

    assign link.s2m_data = tx_data_q;
    assign link.s2m_valid = tx_valid_q;
    assign link.s2m_last = tx_last_q;
    assign reg_rd_addr = rd_addr_q;
    assign cmd_fire = fire_q;
    assign cmd_func = func_q;
    assign cmd_word1 = w1_q;
    assign cmd_word2 = w2_q;
    assign cmd_bcast = bcast_q;
    assign frame_err = err_q;

endmodule : mbc_slave

// ---- sim/mbc_link_properties.sv ----
module mbc_link_chk
    import mbc_pkg::*;
(
    // clock and reset
    input logic core_clk,
    input logic rst,
    // master to slave
    input logic [7:0] m2s_data,
    input logic m2s_valid,
    input logic m2s_last,
    // slave to master
    input logic [7:0] s2m_data,
    input logic s2m_valid,
    input logic s2m_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] m_cnt_q;
    logic [5:0] s_cnt_q;
    logic [15:0] m_crc_q, s_crc_q;
    logic [7:0] r_fn_q, r_bc_q;
    logic [7:0] cmd_q [8];

    // own copy, so a shared slip cannot hide
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
        c = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        return c;
    endfunction : fold

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            m_cnt_q <= 4'h0;
            s_cnt_q <= 6'h00;
            m_crc_q <= 16'hFFFF;
            s_crc_q <= 16'hFFFF;
            r_fn_q <= 8'h00;
            r_bc_q <= 8'h00;
        end else begin
            if (m2s_valid) begin
                cmd_q[m_cnt_q[2:0]] <= m2s_data;
                m_cnt_q <= m2s_last ? 4'h0 : m_cnt_q + 4'h1;
                m_crc_q <= m2s_last ? 16'hFFFF : fold(m_crc_q, m2s_data);
            end
            if (s2m_valid) begin
                s_cnt_q <= s2m_last ? 6'h00 : s_cnt_q + 6'h01;
                s_crc_q <= s2m_last ? 16'hFFFF : fold(s_crc_q, s2m_data);
                r_fn_q <= (s_cnt_q == 6'h01) ? s2m_data : r_fn_q;
                r_bc_q <= (s_cnt_q == 6'h02) ? s2m_data : r_bc_q;
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_cmd_length: assert property (m2s_valid && m2s_last |-> m_cnt_q == 4'h7)
        else $error("bad cmd length");
    a_cmd_residue: assert property (m2s_valid && m2s_last |-> fold(m_crc_q, m2s_data) == 16'h0000)
        else $error("cmd checksum");
    a_rsp_residue: assert property (s2m_valid && s2m_last |-> fold(s_crc_q, s2m_data) == 16'h0000)
        else $error("rsp checksum");
    a_rsp_timing: assert property ($rose(s2m_valid) |-> $past(m2s_last, 2))
        else $error("answer timing");
    a_rsp_unbroken: assert property (s2m_valid && !s2m_last |=> s2m_valid)
        else $error("answer gap");
    a_rsp_addr_back: assert property ($rose(s2m_valid) |-> s2m_data == cmd_q[0])
        else $error("answer station");
    a_read_count: assert property (s2m_valid && s2m_last && r_fn_q == FN_READ
        |-> {2'b00, s_cnt_q} == r_bc_q + 8'h04 && r_bc_q <= 8'h20 && !r_bc_q[0])
        else $error("read length");
    a_exc_shape: assert property (s2m_valid && s2m_last && r_fn_q[7]
        |-> s_cnt_q == 6'h04 && r_fn_q == (cmd_q[1] | FN_EXC_BIT))
        else $error("error answer");
    a_echo_same: assert property (cmd_q[1] == FN_LOOP && s2m_valid |-> s2m_data == cmd_q[s_cnt_q[2:0]])
        else $error("echo byte differs");
    a_bcast_silent: assert property (m2s_valid && m2s_last && cmd_q[0] == BCAST_ADDR |=> !s2m_valid [*4])
        else $error("broadcast answered");
endmodule : mbc_link_chk

// ---- sim/testbench.sv ----
module testbench
    import mbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] own_addr = 8'h01;
    logic req_valid = 1'b0;
    logic [7:0] req_addr = 8'h00, req_func = 8'h00;
    logic [15:0] req_word1 = 16'h0000, req_word2 = 16'h0000;
    logic [3:0] rsp_rd_idx = 4'h0;
    logic [15:0] reg_rd_addr, reg_rd_data, rsp_word;
    logic req_ready, rsp_done, rsp_ok, rsp_exc, rsp_timeout, rsp_echo_ok, cmd_fire, frame_err2;
    logic [7:0] rsp_code, cfn;
    logic [31:0] msk;
    logic [7:0] tx[$], rx[$], fr[$];
    logic [11:0] exp_q[$], msk_q[$];
    int error_cnt = 0, samples_checked = 0;
    int fire_n = 0, exp_fire = 0, err2_n = 0, rx2_n = 0, cyc = 0;

    mbc_link_if link ();
    mbc_link_if link2 ();

    // contents follow the address, so a shifted read shows
    assign reg_rd_data = reg_rd_addr ^ 16'hC35A;

    mbc_master #(.TIMEOUT_CYC(50)) u_mbc_master (.core_clk, .rst, .link, .req_valid, .req_ready,
        .req_addr, .req_func, .req_word1, .req_word2, .rsp_done, .rsp_ok, .rsp_exc, .rsp_timeout,
        .rsp_echo_ok, .rsp_code, .rsp_rd_idx, .rsp_word);
    mbc_slave u_mbc_slave (.core_clk, .rst, .link, .own_addr, .reg_rd_addr, .reg_rd_data,
        .cmd_fire, .cmd_func(cfn), .cmd_word1(), .cmd_word2(), .cmd_bcast(), .frame_err());
    mbc_slave u_mbc_slave_2 (.core_clk, .rst, .link(link2), .own_addr,
        .reg_rd_addr(), .reg_rd_data(16'h0000), .cmd_fire(), .cmd_func(), .cmd_word1(),
        .cmd_word2(), .cmd_bcast(), .frame_err(frame_err2));
    mbc_link_chk u_props (.core_clk, .rst, .m2s_data(link.m2s_data),
        .m2s_valid(link.m2s_valid), .m2s_last(link.m2s_last), .s2m_data(link.s2m_data),
        .s2m_valid(link.s2m_valid), .s2m_last(link.s2m_last));

    initial forever #2.5 core_clk = ~core_clk;

    task automatic check(input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction : crc16

    task automatic build(input logic [7:0] a, f, input logic [15:0] w1, w2);
        logic [15:0] c;
        fr = '{a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
        c = crc16(fr);
        fr.push_back(c[7:0]);
        fr.push_back(c[15:8]);
    endtask : build

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (link.m2s_valid === 1'b1) tx.push_back(link.m2s_data);
        if (link.s2m_valid === 1'b1) rx.push_back(link.s2m_data);
        if (link2.s2m_valid === 1'b1) rx2_n++;
        if (cmd_fire === 1'b1) fire_n++;
        if (frame_err2 === 1'b1) err2_n++;
        if (rsp_done === 1'b1 && exp_q.size() == 0) check(32'h1, 32'h0);
        if (rsp_done === 1'b1 && exp_q.size() > 0) begin
            msk = {20'h0, msk_q.pop_front()};
            check({20'h0, rsp_ok, rsp_exc, rsp_echo_ok, rsp_timeout, rsp_code} & msk,
                {20'h0, exp_q.pop_front()} & msk);
        end
        if (cyc == 10000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic xact(input logic [7:0] a, f, input logic [15:0] w1, w2,
        input logic [11:0] e, m, input int len, fire);
        int n = 0;
        build(a, f, w1, w2);
        exp_q.push_back(e);
        msk_q.push_back(m);
        tx.delete();
        rx.delete();
        req_addr <= a;
        req_func <= f;
        req_word1 <= w1;
        req_word2 <= w2;
        req_valid <= 1'b1;
        @(posedge core_clk);
        req_valid <= 1'b0;
        while (rsp_done !== 1'b1 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        repeat (4) @(posedge core_clk);
        exp_fire += fire;
        check(n < 300, 1'b1);
        check(fire_n, exp_fire);
        if (fire == 1) check(cfn, f);
        check(tx.size(), 8);
        for (int i = 0; i < 8; i++) check(tx[i], fr[i]);
        check(rx.size(), len);
        if (len > 0) begin
            check(rx[0], a);
            check(crc16(rx), 16'h0000);
        end
    endtask : xact

    task automatic raw(input int n);
        for (int i = 0; i < n; i++) begin
            link2.m2s_data <= fr[i];
            link2.m2s_valid <= 1'b1;
            link2.m2s_last <= (i == n - 1);
            @(posedge core_clk);
        end
        link2.m2s_valid <= 1'b0;
        link2.m2s_last <= 1'b0;
        link2.m2s_data <= ~fr[n - 1];
        repeat (20) @(posedge core_clk);
    endtask : raw

    initial begin
        int q;
        logic [15:0] w;
        logic [7:0] f, c;
        link2.m2s_data = 8'h00;
        link2.m2s_valid = 1'b0;
        link2.m2s_last = 1'b0;
        void'($urandom(64970));
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 16'hA537 : 16'($urandom);
            xact(8'h01, FN_LOOP, (i == 0) ? 16'h0000 : 16'($urandom), w, 12'hA00, 12'hF00, 8, 1);
            if (i == 0) check({tx[7], tx[6]}, 16'h8DDA);
            for (int k = 0; k < 8; k++) check(rx[k], fr[k]);
        end
        $display("test loopback done");
        own_addr <= 8'h02;
        for (int i = 0; i < 3; i++) begin
            q = (i == 0) ? 4 : (i == 1) ? 1 : 16;
            w = (i == 0) ? 16'h0020 : 16'($urandom);
            xact(8'h02, FN_READ, w, 16'(q), {4'h8, 8'(2 * q)}, 12'hDFF, 5 + 2 * q, 1);
            for (int k = 0; k < q; k++) begin
                check({rx[3 + 2 * k], rx[4 + 2 * k]}, (w + 16'(k)) ^ 16'hC35A);
                rsp_rd_idx <= 4'(k);
                repeat (2) @(posedge core_clk);
                check(rsp_word, (w + 16'(k)) ^ 16'hC35A);
            end
        end
        $display("test read done");
        for (int i = 0; i < 4; i++) begin
            f = (i < 2) ? FN_READ : (i == 2) ? 8'h10 : 8'h05;
            c = (i < 2) ? EXC_BAD_VALUE : EXC_ILLEGAL_FN;
            xact(8'h02, f, 16'h0000, (i == 0) ? 16'h0000 : 16'h0011, {4'h4, c}, 12'h5FF, 5, 0);
            check({rx[1], rx[2]}, {f | 8'h80, c});
        end
        $display("test error answer done");
        xact(BCAST_ADDR, FN_READ, 16'h0001, 16'h0002, 12'h000, 12'h100, 0, 1);
        $display("test broadcast done");
        xact(8'h55, FN_LOOP, 16'h1234, 16'h5678, 12'h100, 12'h100, 0, 0);
        $display("test foreign done");
        build(8'h02, FN_LOOP, 16'h0001, 16'h0002);
        fr[6] = fr[6] ^ 8'h01;
        raw(8);
        raw(7);
        check(err2_n, 2);
        check(rx2_n, 0);
        fr[6] = fr[6] ^ 8'h01;
        raw(8);
        check(rx2_n, 8);
        check(err2_n, 2);
        $display("test damaged frames done");
        final_report();
    end
endmodule : testbench
